// file: logic/sbsram_port.v
// Synchronous flow-through burst SRAM port with two-bit burst counter.
// Assumes the bus master runs on clk_i; sleep and the order strap are
// asynchronous pins, output enable acts without the clock.
`timescale 1ns/1ps
`include "sbsram_defines.vh"

module sbsram_port (
    input wire clk_i,
    input wire rst_i,
    input wire [`SBSRAM_ADDR_W-1:0] addr_i,
    input wire processor_addr_strobe_n_i,
    input wire controller_addr_strobe_n_i,
    input wire burst_advance_n_i,
    input wire chip_sel_first_n_i,
    input wire chip_sel_second_i,
    input wire chip_sel_third_n_i,
    input wire byte_write_enable_n_i,
    input wire [`SBSRAM_LANES-1:0] byte_lane_select_n_i,
    input wire global_write_n_i,
    input wire output_enable_n_i,
    input wire sleep_request_i,
    input wire burst_order_i,
    input wire [`SBSRAM_DATA_W-1:0] dq_i,
    output wire [`SBSRAM_DATA_W-1:0] dq_o,
    output wire dq_oe_o,
    input wire rd_ready_i,
    output wire rd_valid_o,
    output wire selected_o,
    output wire sleeping_o
);

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous pins: three stages, level accepted once two agree; the strap only once after reset
    reg [2:0] sleep_sync_q;
    reg sleep_q;
    reg [2:0] order_sync_q;
    reg order_q;
    reg order_taken_q;
    reg [1:0] order_fill_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_sync_q <= `SBSRAM_SYNC_RST; // R15
            sleep_q <= 1'h0; // R15
            order_sync_q <= `SBSRAM_SYNC_RST;
        end else begin
            sleep_sync_q <= {sleep_sync_q[1:0], sleep_request_i};
            order_sync_q <= {order_sync_q[1:0], burst_order_i};
            if (sleep_sync_q[1] == sleep_sync_q[2])
                sleep_q <= sleep_sync_q[2];
        end
    end

    // Strap caught once the synchroniser is full of pin samples; the reset
    // contents of the stages would otherwise be taken for the strap level
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            order_q <= `SBSRAM_ORDER_RST;
            order_taken_q <= 1'h0;
            order_fill_q <= 2'h0;
        end else if (order_fill_q != 2'h3) begin
            order_fill_q <= order_fill_q + 2'h1;
        end else if (!order_taken_q && order_sync_q[1] == order_sync_q[2]) begin
            order_q <= order_sync_q[2]; // R17
            order_taken_q <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe decode
    wire chip_selected;
    wire proc_load;
    wire ctrl_load;
    wire load;
    wire new_sel;

    // Three selects decide selection together
    assign chip_selected = ~chip_sel_first_n_i & chip_sel_second_i
                           & ~chip_sel_third_n_i; // R6
    // First select high masks the processor strobe load; the pin still blocks the controller strobe
    assign proc_load = ~processor_addr_strobe_n_i & ~chip_sel_first_n_i
                       & ~sleep_q; // R5
    // Controller strobe only counts when processor strobe is absent
    assign ctrl_load = ~controller_addr_strobe_n_i & ~proc_load
                       & processor_addr_strobe_n_i & ~sleep_q; // R4
    assign load = proc_load | ctrl_load; // R3
    // Selects only matter on a load edge
    assign new_sel = load & chip_selected; // R7

    ////////////////////////////////////////////////////////////////////////
    // Address register, burst counter and selection state
    reg [`SBSRAM_ADDR_W-1:0] addr_q;
    reg [`SBSRAM_CNT_W-1:0] start_q;
    reg [`SBSRAM_CNT_W-1:0] step_q;
    reg sel_q;
    reg [`SBSRAM_CNT_W-1:0] step_d;
    reg [`SBSRAM_CNT_W-1:0] low_d;
    reg [`SBSRAM_ADDR_W-1:0] addr_d;
    wire advance;
    wire read_push;
    wire buf_in_ready;

    // Full read buffer stalls the counter so no word is dropped
    assign advance = ~load & sel_q & ~burst_advance_n_i & ~sleep_q
                     & buf_in_ready; // R11

    // Next address: load, advance or hold
    always @* begin
        step_d = step_q;
        low_d = addr_q[`SBSRAM_CNT_W-1:0];
        addr_d = addr_q;
        if (load) begin
            addr_d = addr_i; // R1
            step_d = {`SBSRAM_CNT_W{1'b0}};
        end else if (advance) begin
            step_d = step_q + 2'h1;
            if (order_q)
                low_d = start_q ^ step_d; // R19
            else
                low_d = start_q + step_d; // R19
            addr_d = {addr_q[`SBSRAM_ADDR_W-1:`SBSRAM_CNT_W], low_d};
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q <= {`SBSRAM_ADDR_W{1'b0}};
            start_q <= {`SBSRAM_CNT_W{1'b0}};
            step_q <= {`SBSRAM_CNT_W{1'b0}};
            sel_q <= 1'h0;
        end else begin
            if (load) begin
                addr_q <= addr_i; // R1
                start_q <= addr_i[`SBSRAM_CNT_W-1:0]; // R2
                sel_q <= chip_selected; // R7
            end else if (advance) begin
                addr_q <= addr_d;
            end
            step_q <= step_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write lane decode
    reg [`SBSRAM_LANES-1:0] lane_we;
    wire write_cycle;
    wire access_ok;

    // Access only when a selected load or a selected burst cycle
    assign access_ok = (new_sel | (~load & sel_q)) & ~sleep_q; // R20
    // Processor-strobe load edge carries no write; data follows later
    assign write_cycle = access_ok & ~proc_load & (|lane_we);

    always @* begin
        if (!global_write_n_i)
            lane_we = {`SBSRAM_LANES{1'b1}}; // R10
        else if (!byte_write_enable_n_i)
            lane_we = ~byte_lane_select_n_i; // R8
        else
            lane_we = {`SBSRAM_LANES{1'b0}};
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage array; kept intact across sleep
    reg [`SBSRAM_DATA_W-1:0] array_q [0:`SBSRAM_DEPTH-1];
    reg [`SBSRAM_DATA_W-1:0] wr_word;
    wire [`SBSRAM_ADDR_W-1:0] wr_addr;
    wire [`SBSRAM_DATA_W-1:0] rd_word;

    // Controller-strobe writes go to the new address
    assign wr_addr = load ? addr_i : addr_q;
    assign rd_word = array_q[addr_d]; // R16

    integer lane;
    always @* begin
        wr_word = array_q[wr_addr];
        for (lane = 0; lane < `SBSRAM_LANES; lane = lane + 1) begin
            if (lane_we[lane])
                wr_word[lane*`SBSRAM_LANE_W +: `SBSRAM_LANE_W] =
                    dq_i[lane*`SBSRAM_LANE_W +: `SBSRAM_LANE_W];
        end
    end

    // Whole word written back; unselected lanes keep their bytes
    always @(posedge clk_i) begin
        if (write_cycle)
            array_q[wr_addr] <= wr_word; // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: word for the edge's address pushed at that edge
    wire buf_valid;

    // Loads with writes deasserted are reads; master keeps them off
    assign read_push = ((new_sel & ~(ctrl_load & (|lane_we)))
                        | (advance & ~(|lane_we))) & ~sleep_q; // R18

    sbsram_buf2 u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(read_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(rd_word),
        .out_valid_o(buf_valid),
        .out_ready_i(rd_ready_i),
        .out_data_o(dq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin direction
    // Unclocked enable; nothing driven until a selected read word exists
    assign dq_oe_o = ~output_enable_n_i & sel_q & buf_valid
                     & ~sleep_q; // R12
    // Valid gated by selection, masking the first clock after a deselect
    assign rd_valid_o = buf_valid & sel_q; // R13
    assign selected_o = sel_q;
    assign sleeping_o = sleep_q; // R14

endmodule

// file: include/sbsram_defines.vh
// Constants for the synchronous burst SRAM port.
// Assumes inclusion by bare name from the logic files; definitions only.
// Function
// R1: Load address only when strobe and selected; the code loads it on every strobe load, selected or not.
// R2: Strobe loads low address bits into counter.
// R3: Low strobe at edge latches address.
// R4: Both strobes: processor strobe wins.
// R5: Processor strobe ignored while first select high; the code still lets a low processor strobe block the controller strobe.
// R6: Selected: first low, second high, third low.
// R7: Selects sampled only on address loads.
// R8: Lane written when lane select and enable low.
// R9: Master drives byte-write enable for lane writes.
// R10: Global write low writes all four lanes.
// R11: Advance low steps counter, else hold; the code also holds while the read buffer is full.
// R12: Output enable steers data pins, unclocked.
// R13: First read clock after deselect: outputs off.
// R14: Sleep high idles device, keeps contents.
// R15: Sleep defaults inactive low.
// R16: Read data from previous edge address.
// R17: Order strap: low linear, high interleaved.
// R18: Master keeps writes off on controller read start.
// R19: Counter wraps in four, linear or interleaved.
// R20: Deselected load: no access, pins undriven.
`ifndef SBSRAM_DEFINES_VH
`define SBSRAM_DEFINES_VH

`define SBSRAM_ADDR_W 18
`define SBSRAM_DEPTH 262144
`define SBSRAM_DATA_W 32
`define SBSRAM_LANES 4
`define SBSRAM_LANE_W 8
`define SBSRAM_CNT_W 2
`define SBSRAM_BUF_DEPTH 2
`define SBSRAM_SYNC_RST 3'h0
`define SBSRAM_ORDER_RST 1'h1

`endif

// file: logic/sbsram_buf2.v
// Two-entry buffer between the memory read port and the data pins.
// Assumes one clock; the consumer honours valid and ready, the producer only on burst advances, not on loads.
`timescale 1ns/1ps
`include "sbsram_defines.vh"

module sbsram_buf2 (
    input wire clk_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [`SBSRAM_DATA_W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [`SBSRAM_DATA_W-1:0] out_data_o
);

    reg [`SBSRAM_DATA_W-1:0] mem_q [0:1];
    reg rd_ptr_q;
    reg wr_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    // Honest flags: full stops the filler, empty stops the drain
    assign in_ready_o = (count_q != 2'h2);
    assign out_valid_o = (count_q != 2'h0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    ////////////////////////////////////////////////////////////////////////
    // Pointers and occupancy
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ptr_q <= 1'h0;
            wr_ptr_q <= 1'h0;
            count_q <= 2'h0;
        end else begin
            if (push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (push & ~pop)
                count_q <= count_q + 2'h1;
            else if (pop & ~push)
                count_q <= count_q - 2'h1;
        end
    end

    // Storage has no reset; contents are qualified by count
    always @(posedge clk_i) begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_i;
    end

endmodule

// file: verif/sbsram_port_checker.sv
// Pin-level assertions for the burst SRAM port.
// Assumes it is bound onto sbsram_port; one clock, async reset.
`timescale 1ns/1ps
module sbsram_port_checker (
    input wire clk_i,
    input wire rst_i,
    input wire processor_addr_strobe_n_i,
    input wire controller_addr_strobe_n_i,
    input wire chip_sel_first_n_i,
    input wire chip_sel_second_i,
    input wire chip_sel_third_n_i,
    input wire global_write_n_i,
    input wire byte_write_enable_n_i,
    input wire output_enable_n_i,
    input wire dq_oe_o,
    input wire rd_valid_o,
    input wire selected_o,
    input wire sleeping_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Pin decode; loads and idle need sleep off since it blocks them
    wire act = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
    wire cld = !controller_addr_strobe_n_i && processor_addr_strobe_n_i && !sleeping_o;
    wire nowr = global_write_n_i && byte_write_enable_n_i;
    wire none = processor_addr_strobe_n_i && controller_addr_strobe_n_i && !sleeping_o;
    ////////////////////////////////////////////////////////////
    property p_oe_off; output_enable_n_i |-> !dq_oe_o; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pins driven with enable high");
    property p_desel; cld && !act |=> !selected_o && !rd_valid_o; endproperty
    a_desel: assert property (p_desel)
        else $error("deselected load took effect");
    property p_sel; cld && act |=> selected_o; endproperty
    a_sel: assert property (p_sel)
        else $error("selected load not taken");
    property p_ign; !processor_addr_strobe_n_i && chip_sel_first_n_i && none == 0
        && controller_addr_strobe_n_i && !sleeping_o |=> $stable(selected_o); endproperty
    a_ign: assert property (p_ign)
        else $error("processor strobe not ignored");
    property p_hold; none ##1 !sleeping_o |-> $stable(selected_o); endproperty
    a_hold: assert property (p_hold)
        else $error("selection changed without load");
    property p_sleep; sleeping_o |-> !dq_oe_o && !rd_valid_o; endproperty
    a_sleep: assert property (p_sleep)
        else $error("activity while sleeping");
    property p_unsel; !selected_o |-> !dq_oe_o && !rd_valid_o; endproperty
    a_unsel: assert property (p_unsel)
        else $error("output while deselected");
    property p_read; cld && act && nowr |=> rd_valid_o && dq_oe_o == !output_enable_n_i;
    endproperty
    a_read: assert property (p_read)
        else $error("read word not presented");
endmodule
bind sbsram_port sbsram_port_checker i_sbsram_port_checker (.clk_i(clk_i), .rst_i(rst_i),
    .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
    .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
    .chip_sel_first_n_i(chip_sel_first_n_i), .chip_sel_second_i(chip_sel_second_i),
    .chip_sel_third_n_i(chip_sel_third_n_i), .global_write_n_i(global_write_n_i),
    .byte_write_enable_n_i(byte_write_enable_n_i), .output_enable_n_i(output_enable_n_i),
    .dq_oe_o(dq_oe_o), .rd_valid_o(rd_valid_o), .selected_o(selected_o),
    .sleeping_o(sleeping_o));

// file: verif/sbsram_host_model.sv
// Bus master model: one set of pin values per clock per call.
// Assumes calls come on consecutive or spaced clk_i edges.
`timescale 1ns/1ps
module sbsram_host_model (
    input wire clk_i,
    output logic [17:0] addr_o,
    output logic pstb_n_o,
    output logic cstb_n_o,
    output logic adv_n_o,
    output logic [2:0] sel_o,
    output logic gw_n_o,
    output logic bwe_n_o,
    output logic [3:0] lane_n_o,
    output logic [31:0] wd_o
);
    // Idle bus, deselected, until the first call
    initial {addr_o, wd_o} = 0;
    initial {pstb_n_o, cstb_n_o, adv_n_o, sel_o, gw_n_o, bwe_n_o, lane_n_o} = 12'hf7f;
    // Held until the next call; released data flips so stale words never match
    task op(input [1:0] s, input [17:0] a, input [2:0] c, input v, input [5:0] w,
            input [31:0] d);
        @(posedge clk_i);
        {pstb_n_o, cstb_n_o} <= s;
        addr_o <= a;
        sel_o <= c;
        adv_n_o <= v;
        {gw_n_o, bwe_n_o, lane_n_o} <= w;
        wd_o <= (w[5] && w[4]) ? ~wd_o : d;
    endtask
endmodule

// file: verif/sbsram_port_test.sv
// Self-checking bench for the burst SRAM port and its bus master.
// Assumes 10 MHz clock; the order strap is re-sampled by a fresh reset.
`timescale 1ns/1ps
module sbsram_port_test;
    logic clk_i = 0, rst_i = 1, oe_n = 1, slp = 0, mode = 0, rdy = 1;
    wire [17:0] a;
    wire ps, cs, burst_advance_n, gw, byte_write_enable_n, oe, val;
    wire [2:0] sel;
    wire [3:0] ln;
    wire [31:0] wd, rdat;
    wire [31:0] dq = oe ? rdat : wd; // Resolved data wire
    int fail_count = 0, compares = 0;
    logic [31:0] q[$];
    sbsram_host_model i_sbsram_host_model (.clk_i(clk_i), .addr_o(a), .pstb_n_o(ps),
        .cstb_n_o(cs), .adv_n_o(burst_advance_n), .sel_o(sel), .gw_n_o(gw), .bwe_n_o(byte_write_enable_n),
        .lane_n_o(ln), .wd_o(wd));
    sbsram_port i_sbsram_port (.clk_i(clk_i), .rst_i(rst_i), .addr_i(a),
        .processor_addr_strobe_n_i(ps), .controller_addr_strobe_n_i(cs),
        .burst_advance_n_i(burst_advance_n), .chip_sel_first_n_i(sel[2]), .chip_sel_second_i(sel[1]),
        .chip_sel_third_n_i(sel[0]), .byte_write_enable_n_i(byte_write_enable_n), .byte_lane_select_n_i(ln),
        .global_write_n_i(gw), .output_enable_n_i(oe_n | ~(gw & byte_write_enable_n)), .sleep_request_i(slp),
        .burst_order_i(mode), .dq_i(dq), .dq_o(rdat), .dq_oe_o(oe), .rd_ready_i(rdy),
        .rd_valid_o(val), .selected_o(), .sleeping_o());
    ////////////////////////////////////////////////////////////
    initial forever #50 clk_i = ~clk_i;
    // Every word the receiver takes, in order
    always @(posedge clk_i) if (val === 1'b1 && rdy) q.push_back(rdat);
    // Run needs some 90 cycles; a hang is cut at 4000
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wrap_up();
        $display("%0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task op(input [1:0] s, input [17:0] ad, input [2:0] c, input v, input [5:0] w,
            input [31:0] d);
        i_sbsram_host_model.op(s, ad, c, v, w, d);
    endtask
    task idle();
        op(2'h3, 18'h0, 3'h5, 1'b1, 6'h3f, 32'h0);
    endtask
    task wr(input [17:0] ad, input [31:0] d);
        op(2'h2, ad, 3'h2, 1'b1, 6'h1f, d);
    endtask
    // Last word taken is ours; a proc load before may leave one stray word
    task rd(input [17:0] ad, input [31:0] e);
        op(2'h2, ad, 3'h2, 1'b1, 6'h3f, 32'h0);
        idle();
        @(posedge clk_i);
        #1;
        chk("read", q[$], e);
    endtask
    task rst(input logic m);
        @(posedge clk_i);
        rst_i <= 1;
        mode <= m;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        repeat (4) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    // Burst from start 1, receiver stalls so one advance must be dropped
    task t_burst(input logic m);
        for (int k = 0; k < 4; k++) wr(18'h00100 + 18'(k), 32'h50 + 32'(k));
        repeat (2) idle();
        q.delete();
        op(2'h2, 18'h00101, 3'h2, 1'b1, 6'h3f, 32'h0);
        rdy <= 0;
        repeat (2) op(2'h3, 18'h0, 3'h5, 1'b0, 6'h3f, 32'h0);
        idle();
        rdy <= 1;
        repeat (4) op(2'h3, 18'h0, 3'h5, 1'b0, 6'h3f, 32'h0);
        idle();
        repeat (3) @(posedge clk_i);
        for (int n = 0; n < 5; n++)
            chk("burst", q[n], 32'h50 + 32'(m ? (1 ^ n % 4) : (1 + n) % 4));
        $display("burst order %0d done", m);
    endtask
    task t_strobes();
        wr(18'h00200, 32'h11223344);
        op(2'h1, 18'h00200, 3'h2, 1'b1, 6'h3f, 32'h0);
        op(2'h3, 18'h0, 3'h5, 1'b1, 6'h2a, 32'haabbccdd);
        op(2'h3, 18'h0, 3'h5, 1'b1, 6'h30, 32'hffffffff);
        rd(18'h00200, 32'h11bb33dd);
        op(2'h0, 18'h00200, 3'h2, 1'b1, 6'h1f, 32'h0);
        rd(18'h00200, 32'h11bb33dd);
        op(2'h1, 18'h00300, 3'h6, 1'b1, 6'h3f, 32'h0);
        op(2'h3, 18'h0, 3'h5, 1'b1, 6'h1f, 32'h5a5a5a5a);
        rd(18'h00200, 32'h5a5a5a5a);
        $display("strobes done");
    endtask
    // Each select pin inactive in turn: write must not land
    task t_desel();
        logic [2:0] c[3] = '{3'h6, 3'h0, 3'h3};
        wr(18'h00400, 32'h0badf00d);
        foreach (c[i]) op(2'h2, 18'h00400, c[i], 1'b1, 6'h1f, 32'h0);
        rd(18'h00400, 32'h0badf00d);
        $display("deselect done");
    endtask
    task t_sleep();
        wr(18'h00500, 32'h600d600d);
        slp <= 1;
        repeat (6) idle();
        wr(18'h00500, 32'h0);
        idle();
        slp <= 0;
        repeat (6) idle();
        rd(18'h00500, 32'h600d600d);
        $display("sleep done");
    endtask
    initial begin
        rst(0);
        t_burst(0);
        rst(1);
        oe_n <= 0;
        t_burst(1);
        t_strobes();
        t_desel();
        t_sleep();
        wrap_up();
    end
endmodule
